//--- hw/ctw_timer.v
// Register access over AXI4-Lite was left to the implementer.
`include "ctw_consts.vh"
module ctw_timer #(
  parameter STAB_CYC = `CTW_STAB_CYC
) (
  input wire aclk,
  input wire aresetn,
  input wire [9:0] s_axi_awaddr,
  input wire [2:0] s_axi_awprot,
  input wire s_axi_awvalid,
  output reg s_axi_awready,
  input wire [31:0] s_axi_wdata,
  input wire [3:0] s_axi_wstrb,
  input wire s_axi_wvalid,
  output reg s_axi_wready,
  output reg [1:0] s_axi_bresp,
  output reg s_axi_bvalid,
  input wire s_axi_bready,
  input wire [9:0] s_axi_araddr,
  input wire [2:0] s_axi_arprot,
  input wire s_axi_arvalid,
  output reg s_axi_arready,
  output reg [31:0] s_axi_rdata,
  output reg [1:0] s_axi_rresp,
  output reg s_axi_rvalid,
  input wire s_axi_rready,
  input wire cpu_irq_mask,
  input wire wake_event,
  output reg timer_irq,
  output reg wake_request,
  output reg watchdog_reset,
  output reg stopped
);
  localparam ST_RUN = 3'b001;
  localparam ST_STOP = 3'b010;
  localparam ST_STAB = 3'b100;

  reg [2:0] state;
  reg [15:0] stab_cnt;
  reg overflow_flag;
  reg periodic_flag;
  reg overflow_irq_enable;
  reg periodic_irq_enable;
  reg [1:0] rate_sel;
  reg [2:0] mode;
  reg [`CTW_WD_W-1:0] wd_div;
  reg [9:0] awaddr_q;
  reg [31:0] wdata_q;
  reg [3:0] wstrb_q;
  reg aw_have;
  reg w_have;
  wire [`CTW_CHAIN_W-1:0] chain;
  wire ovf_evt;
  wire [3:0] tap_evt;
  wire chain_clear;
  wire chain_run;
  wire sel_evt;
  wire wr_go;
  wire wr_csr;
  wire wr_wd;
  wire wr_mode;
  wire [7:0] csr_rd;
  wire next_irq;

  // true when address hits a mapped word
  function mapped;
    input [9:0] a;
    begin
      mapped = (a == `CTW_ADDR_CSR) || (a == `CTW_ADDR_CNT) ||
               (a == `CTW_ADDR_WDCLR) || (a == `CTW_ADDR_MODE);
    end
  endfunction

  // chain held clear in reset, stop and stabilization
  assign chain_clear = !aresetn || (state != ST_RUN);
  assign chain_run = (state == ST_RUN);

  ctw_chain u_chain (
    .aclk(aclk),
    .clear(chain_clear),
    .run(chain_run),
    .count(chain),
    .ovf_evt(ovf_evt),
    .tap_evt(tap_evt)
  );

  assign sel_evt = tap_evt[rate_sel];

  // write decode
  assign wr_go = aw_have && w_have && !s_axi_bvalid;
  assign wr_csr = wr_go && (awaddr_q == `CTW_ADDR_CSR) && wstrb_q[0];
  assign wr_wd = wr_go && (awaddr_q == `CTW_ADDR_WDCLR) && wstrb_q[0];
  assign wr_mode = wr_go && (awaddr_q == `CTW_ADDR_MODE) && wstrb_q[0];

  // clear bits always read zero
  assign csr_rd = {overflow_flag, periodic_flag, overflow_irq_enable,
                   periodic_irq_enable, 2'b00, rate_sel};

  // address and data channels captured in either order
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      awaddr_q <= 10'h000;
      wdata_q <= 32'h00000000;
      wstrb_q <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        awaddr_q <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        wdata_q <= s_axi_wdata;
        wstrb_q <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= mapped(awaddr_q) ? 2'h0 : 2'h2;
        aw_have <= 1'b0;
        w_have <= 1'b0;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // read channel: one-cycle address accept, data next cycle
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= 2'h0;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= mapped(s_axi_araddr) ? 2'h0 : 2'h2;
      case (s_axi_araddr)
        `CTW_ADDR_CSR: s_axi_rdata <= {24'h000000, csr_rd};
        `CTW_ADDR_CNT: s_axi_rdata <= {24'h000000, chain[9:2]};
        `CTW_ADDR_MODE: s_axi_rdata <= {29'h00000000, mode};
        default: s_axi_rdata <= 32'h00000000;
      endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

  // flags: hardware set wins over software clear
  always @(posedge aclk) begin
    if (!aresetn) begin
      overflow_flag <= 1'b0;
      periodic_flag <= 1'b0;
      overflow_irq_enable <= 1'b0;
      periodic_irq_enable <= 1'b0;
      rate_sel <= `CTW_RATE_RST;
    end else begin
      if (ovf_evt) begin
        overflow_flag <= 1'b1;
      end else if (wr_csr && wdata_q[`CTW_BIT_OVFC]) begin
        overflow_flag <= 1'b0;
      end
      if (sel_evt) begin
        periodic_flag <= 1'b1;
      end else if (wr_csr && wdata_q[`CTW_BIT_PERC]) begin
        periodic_flag <= 1'b0;
      end
      if (wr_csr) begin
        // flag positions of the write are dropped
        overflow_irq_enable <= wdata_q[`CTW_BIT_OVFE];
        periodic_irq_enable <= wdata_q[`CTW_BIT_PERE];
        rate_sel <= wdata_q[`CTW_BIT_RTHI:`CTW_BIT_RTLO];
      end
    end
  end

  // interrupt request level and wake from wait
  assign next_irq = ((overflow_flag && overflow_irq_enable) ||
                     (periodic_flag && periodic_irq_enable));
  always @(posedge aclk) begin
    if (!aresetn) begin
      timer_irq <= 1'b0;
      wake_request <= 1'b0;
    end else begin
      timer_irq <= next_irq && !cpu_irq_mask;
      wake_request <= next_irq && mode[`CTW_BIT_WAIT];
    end
  end

  // low-power mode bits; wait clears on wake
  always @(posedge aclk) begin
    if (!aresetn) begin
      mode <= `CTW_MODE_RST;
    end else if (wr_mode) begin
      mode <= wdata_q[2:0];
    end else begin
      if (state == ST_STOP && wake_event) begin
        mode[`CTW_BIT_STOP] <= 1'b0;
      end
      if (next_irq && mode[`CTW_BIT_WAIT]) begin
        mode[`CTW_BIT_WAIT] <= 1'b0;
      end
    end
  end

  // stop entry, oscillator restart delay, then resume
  always @(posedge aclk) begin
    if (!aresetn) begin
      state <= ST_RUN;
      stab_cnt <= 16'h0000;
      stopped <= 1'b0;
    end else begin
      case (state)
        ST_RUN: begin
          if (mode[`CTW_BIT_STOP]) begin
            state <= ST_STOP;
            stopped <= 1'b1;
          end
        end
        ST_STOP: begin
          if (wake_event) begin
            state <= ST_STAB;
            stab_cnt <= 16'h0000;
          end
        end
        ST_STAB: begin
          if (stab_cnt == STAB_CYC[15:0] - 16'h0001) begin
            state <= ST_RUN;
            stopped <= 1'b0;
          end else begin
            stab_cnt <= stab_cnt + 16'h0001;
          end
        end
        default: begin
          state <= ST_RUN;
          stopped <= 1'b0;
        end
      endcase
    end
  end

  // watchdog: divide selected tap by eight, clear on zero write
  always @(posedge aclk) begin
    if (!aresetn) begin
      wd_div <= {`CTW_WD_W{1'b0}};
      watchdog_reset <= 1'b0;
    end else begin
      watchdog_reset <= 1'b0;
      if (wr_wd && !wdata_q[`CTW_BIT_WDCLR]) begin
        wd_div <= {`CTW_WD_W{1'b0}};
      end else if (sel_evt && mode[`CTW_BIT_WDEN]) begin
        wd_div <= wd_div + {{(`CTW_WD_W-1){1'b0}}, 1'b1};
        if (&wd_div) begin
          watchdog_reset <= 1'b1;
        end
      end
    end
  end
endmodule // ctw_timer

//--- shared/ctw_consts.vh
`ifndef CTW_CONSTS_VH
`define CTW_CONSTS_VH
// register byte addresses (printed offsets are not multiples of four)
`define CTW_IDX_CSR 8'h08
`define CTW_IDX_CNT 8'h09
`define CTW_IDX_WDCLR 8'h0a
`define CTW_IDX_MODE 8'h0b
`define CTW_ADDR_CSR 10'h020
`define CTW_ADDR_CNT 10'h024
`define CTW_ADDR_WDCLR 10'h028
`define CTW_ADDR_MODE 10'h02c
// control/status field positions
`define CTW_BIT_OVF 7
`define CTW_BIT_PER 6
`define CTW_BIT_OVFE 5
`define CTW_BIT_PERE 4
`define CTW_BIT_OVFC 3
`define CTW_BIT_PERC 2
`define CTW_BIT_RTHI 1
`define CTW_BIT_RTLO 0
`define CTW_BIT_WDCLR 0
`define CTW_BIT_STOP 0
`define CTW_BIT_WAIT 1
`define CTW_BIT_WDEN 2
// reset values
`define CTW_RATE_RST 2'h3
`define CTW_MODE_RST 3'h4
// chain geometry: prescale 2, counter 8, three stages, four rti stages
`define CTW_CHAIN_W 17
`define CTW_TAP_BASE 13
`define CTW_WD_W 3
// stabilization delay in ns and its count of cycles at 10 ns
`define CTW_STAB_NS 40640
`define CTW_CLK_NS 10
`define CTW_STAB_CYC (`CTW_STAB_NS / `CTW_CLK_NS)
`endif

//--- hw/ctw_chain.v
`include "ctw_consts.vh"
// prescaler and ripple chain modelled as a synchronous binary count
module ctw_chain (
  input wire aclk,
  input wire clear,
  input wire run,
  output reg [`CTW_CHAIN_W-1:0] count,
  output wire ovf_evt,
  output wire [3:0] tap_evt
);
  wire [`CTW_CHAIN_W-1:0] nxt;
  assign nxt = count + {{(`CTW_CHAIN_W-1){1'b0}}, 1'b1};
  // counter wraps ff to 00 when bits 9..0 all one
  assign ovf_evt = run & (&count[9:0]);
  // each tap fires when its stage (14..17) completes a period
  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_tap
      assign tap_evt[g] = run & (&count[`CTW_TAP_BASE+g:0]);
    end
  endgenerate
  // chain clears on reset, stop or stabilization, else advances
  always @(posedge aclk) begin
    if (clear) begin
      count <= {`CTW_CHAIN_W{1'b0}};
    end else if (run) begin
      count <= nxt;
    end
  end
endmodule // ctw_chain

//--- verification/ctw_timer_chk.sv
module ctw_timer_chk (
  input wire aclk,
  input wire aresetn,
  input wire s_axi_awvalid,
  input wire s_axi_awready,
  input wire s_axi_wready,
  input wire s_axi_bvalid,
  input wire s_axi_arvalid,
  input wire s_axi_arready,
  input wire [9:0] s_axi_araddr,
  input wire s_axi_rvalid,
  input wire [31:0] s_axi_rdata,
  input wire [1:0] s_axi_rresp,
  input wire cpu_irq_mask,
  input wire timer_irq,
  input wire watchdog_reset,
  input wire stopped
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // read address accepted
  sequence s_ar;
    s_axi_arvalid && s_axi_arready;
  endsequence
  AST_MASK: assert property (cpu_irq_mask |=> !timer_irq)
    else $error("irq while masked");
  AST_RVAL: assert property (s_ar |=> s_axi_rvalid)
    else $error("read answer late");
  AST_UNMAP: assert property (s_ar ##0 s_axi_araddr == 10'h3fc
    |=> s_axi_rresp == 2'h2 && s_axi_rdata == 32'h0)
    else $error("unmapped read not refused");
  AST_REFUSE: assert property (s_axi_bvalid
    |-> !s_axi_awready && !s_axi_wready)
    else $error("write taken during response");
  AST_ARLOW: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  AST_RST: assert property ($rose(aresetn)
    |-> !timer_irq && !stopped && !watchdog_reset)
    else $error("outputs not cleared by reset");
  AST_WDP: assert property (watchdog_reset |=> !watchdog_reset)
    else $error("watchdog pulse too long");
  AST_LVL: assert property (timer_irq && !cpu_irq_mask
    && s_axi_awready && !s_axi_awvalid |=> timer_irq)
    else $error("irq level dropped");
endmodule // ctw_timer_chk

bind ctw_timer ctw_timer_chk u_chk (.*);

//--- verification/ctw_cpu_model.sv
module ctw_cpu_model (
  input wire aclk,
  input wire aresetn,
  input wire timer_irq,
  input wire mask_req,
  output reg cpu_irq_mask,
  output reg [7:0] irq_taken
);
  timeunit 1ns;
  timeprecision 1ns;
  initial cpu_irq_mask = 1'b1;
  // mask bit set by reset, then follows the program; count taken irqs
  always @(posedge aclk) begin
    cpu_irq_mask <= !aresetn || mask_req;
    if (!aresetn)
      irq_taken <= 8'h00;
    else if (timer_irq && !cpu_irq_mask)
      irq_taken <= irq_taken + 8'h01;
  end
endmodule // ctw_cpu_model

//--- verification/tb_ctw_timer.sv
`include "ctw_consts.vh"
module tb_ctw_timer;
  timeunit 1ns;
  timeprecision 1ns;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [9:0] awaddr = 10'h000;
  reg [9:0] araddr = 10'h000;
  reg [31:0] wdata = 32'h0;
  reg awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0;
  reg arvalid = 1'b0, rready = 1'b0, mask_req = 1'b0, wake = 1'b0;
  wire awready, wready, bvalid, arready, rvalid, mask, irq, stp;
  wire [1:0] bresp, rresp;
  wire [31:0] rdata;
  integer n_errors = 0, check_count = 0, cyc = 0, t0, i;
  integer seed = 32'h126f2fc3;
  reg [31:0] rd;
  reg [1:0] rs;
  reg [7:0] v;
  ctw_timer #(.STAB_CYC(20)) uut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awprot(3'h0),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'h1),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arprot(3'h0),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .cpu_irq_mask(mask), .wake_event(wake), .timer_irq(irq),
    .wake_request(), .watchdog_reset(), .stopped(stp));
  ctw_cpu_model cpu (.aclk(aclk), .aresetn(aresetn), .timer_irq(irq),
    .mask_req(mask_req), .cpu_irq_mask(mask), .irq_taken());
  initial forever #5 aclk = ~aclk;
  always @(posedge aclk) cyc <= cyc + 1;
  // readable control/status bits after a write
  function [7:0] csr_exp(input [7:0] w);
    csr_exp = w & 8'h33;
  endfunction
  task chk(input [31:0] got, input [31:0] exp);
    begin
      check_count = check_count + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("Error %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task wr(input [9:0] a, input [7:0] d);
    begin
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      do begin
        @(posedge aclk);
        if (awready) awvalid <= 1'b0;
        if (wready) wvalid <= 1'b0;
      end while (!bvalid);
      bready <= 1'b0;
      rs = bresp;
    end
  endtask
  task rd_reg(input [9:0] a);
    begin
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      do begin
        @(posedge aclk);
        if (arready) arvalid <= 1'b0;
      end while (!rvalid);
      rready <= 1'b0;
      rd = rdata;
      rs = rresp;
    end
  endtask
  // read the status until the given flag shows
  task poll(input integer b, input integer n);
    integer k;
    begin
      k = 0;
      do begin
        rd_reg(`CTW_ADDR_CSR);
        k = k + 1;
      end while (!rd[b] && k < n);
    end
  endtask
  task summarize;
    begin
      $display("errors %0d checks %0d", n_errors, check_count);
      if (n_errors == 0 && check_count > 0)
        $display("All tests passed");
      else
        $display("Some tests failed");
      $finish;
    end
  endtask
  initial begin
    #800000;
    n_errors = n_errors + 1;
    summarize;
  end
  // main sequence
  initial begin
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`CTW_ADDR_CSR);
    chk(rd, 32'h03);
    rd_reg(10'h3fc);
    chk(rs, 2'h2);
    for (i = 0; i < 8; i = i + 1) begin
      v = $random(seed);
      wr(`CTW_ADDR_CSR, v);
      rd_reg(`CTW_ADDR_CSR);
      chk(rd & 32'h3f, csr_exp(v));
    end
    wr(`CTW_ADDR_CSR, 8'h20);
    poll(7, 400);
    chk(rd[7:0], 8'ha0);
    repeat (2) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`CTW_ADDR_CSR, 8'h20);
    rd_reg(`CTW_ADDR_CSR);
    chk(rd[7:0], 8'ha0);
    wr(`CTW_ADDR_CSR, 8'h28);
    rd_reg(`CTW_ADDR_CSR);
    chk(rd[7:0], 8'h20);
    wr(`CTW_ADDR_WDCLR, 8'h00);
    wr(`CTW_ADDR_CSR, 8'h10);
    poll(6, 9000);
    t0 = cyc;
    chk(rd[6], 1'b1);
    mask_req <= 1'b1;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b0);
    mask_req <= 1'b0;
    repeat (3) @(posedge aclk);
    chk(irq, 1'b1);
    wr(`CTW_ADDR_MODE, 8'h06);
    rd_reg(`CTW_ADDR_MODE);
    chk(rd, 32'h04);
    wr(`CTW_ADDR_CSR, 8'h14);
    rd_reg(`CTW_ADDR_CSR);
    chk(rd[6], 1'b0);
    poll(6, 9000);
    chk(cyc - t0 > 16370 && cyc - t0 < 16400, 1'b1);
    wr(`CTW_ADDR_WDCLR, 8'h00);
    chk(rs, 2'h0);
    wr(`CTW_ADDR_MODE, 8'h05);
    rd_reg(`CTW_ADDR_CNT);
    chk(rd, 32'h0);
    chk(stp, 1'b1);
    wake <= 1'b1;
    @(posedge aclk);
    wake <= 1'b0;
    i = 0;
    while (stp && i < 200) begin
      @(posedge aclk);
      i = i + 1;
    end
    chk(i >= 20 && i < 60, 1'b1);
    aresetn <= 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    rd_reg(`CTW_ADDR_CSR);
    chk(rd, 32'h03);
    rd_reg(`CTW_ADDR_CNT);
    v = rd[7:0];
    repeat (40) @(posedge aclk);
    rd_reg(`CTW_ADDR_CNT);
    chk(rd[7:0] - v >= 10 && rd[7:0] - v <= 12, 1'b1);
    summarize;
  end
endmodule // tb_ctw_timer
